// File: hw/pmx_pkg.sv
// Purpose: shared constants and carrier types for the port 4 pin router
// Assumes: pin index 0..3 stands for port pins 4.4..4.7
// Notes: no register bus; control bits arrive as write strobes with data
package pmx_pkg;
   localparam int PMX_PINS = 4;
   // pin slots within the routed group
   localparam int PMX_PIN_B_RX = 0; // pin 4.4
   localparam int PMX_PIN_A_RX = 1; // pin 4.5
   localparam int PMX_PIN_A_TX = 2; // pin 4.6
   localparam int PMX_PIN_B_TX = 3; // pin 4.7
   localparam int PMX_IRQ_LINES = 4;
   localparam int PMX_ADDR_W = 16;
   localparam int PMX_OFS_W = 8;
   localparam int PMX_SEL_BIT = 8; // address bit telling the two can controllers apart
   localparam logic [3:0] PMX_SEG_LINES_ALL = 4'h8;
   localparam logic [3:0] PMX_SEG_LINES_CAN = 4'h4;
   localparam logic [6:0] PMX_MSG_OBJ_PER_CAN = 7'h20;
   localparam logic [3:0] PMX_PIN_IDLE = 4'hF; // pulled-up idle level of the pins
   localparam logic PMX_RECESSIVE = 1'b1;

   // peripheral select fields
   typedef struct packed {
      logic i2c_block_enable;
      logic misc_reg_enable;
      logic can_b_enable;
      logic can_a_enable;
   } pmx_persel_t;

   localparam pmx_persel_t PMX_PERSEL_RST = '{i2c_block_enable: 1'b0,
      misc_reg_enable: 1'b0, can_b_enable: 1'b0, can_a_enable: 1'b1};

   // drive of the four routed pins
   typedef struct packed {
      logic [PMX_PINS-1:0] out;
      logic [PMX_PINS-1:0] oe;
   } pmx_pin_drive_t;
endpackage

// File: hw/pmx_pin_sync.sv
// Purpose: three-stage input synchroniser with agreement filter
// Assumes: inputs are asynchronous pin levels
// Notes: output changes only once stages two and three agree
`timescale 1ns/1ps
module pmx_pin_sync #(
   parameter int WIDTH = 4,
   parameter logic [WIDTH-1:0] RST_VAL = '1
) (
   input wire logic sys_clk, // system clock
   input wire logic rst_b, // async reset, active low
   input wire logic [WIDTH-1:0] d, // raw pin levels
   output logic [WIDTH-1:0] q // filtered levels
);
   logic [WIDTH-1:0] s1_reg;
   logic [WIDTH-1:0] s2_reg;
   logic [WIDTH-1:0] s3_reg;

   // chain; s1 feeds only s2 to keep metastability contained
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         s1_reg <= RST_VAL;
         s2_reg <= RST_VAL;
         s3_reg <= RST_VAL;
      end else begin
         s1_reg <= d;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   // per-bit agreement filter
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         q <= RST_VAL;
      end else begin
         for (int i = 0; i < WIDTH; i++) begin
            if (s2_reg[i] == s3_reg[i]) begin
               q[i] <= s3_reg[i];
            end
         end
      end
   end
endmodule

// File: hw/pmx_router.sv
// Purpose: routes two can controllers and the i2c controller onto port pins 4.4..4.7
// Assumes: controller signals are on sys_clk; pins are asynchronous
// Notes: every output is registered, so routing lags the controls by one edge
`timescale 1ns/1ps
module pmx_router #(
   parameter logic [pmx_pkg::PMX_ADDR_W-1:0] CAN_BASE = 16'h0000 // base of controller a
) (
   input wire logic sys_clk, // 250 MHz system clock
   input wire logic rst_b, // async reset, active low
   input wire logic persel_wr, // write strobe, peripheral select
   input wire pmx_pkg::pmx_persel_t persel_wdata, // peripheral select data
   input wire logic ext_periph_enable, // extension peripheral enable level
   input wire logic misc_wr, // write strobe, misc control
   input wire logic misc_wdata, // parallel mode bit to write
   input wire logic [pmx_pkg::PMX_PINS-1:0] port_value_reg, // port output values
   input wire logic [pmx_pkg::PMX_PINS-1:0] port_direction_reg, // 1 = output
   input wire logic [pmx_pkg::PMX_PINS-1:0] port_open_drain_reg, // 1 = open-drain
   input wire logic [pmx_pkg::PMX_PINS-1:0] pin_in, // pin levels
   input wire logic can_a_transmit, // controller a tx
   input wire logic can_b_transmit, // controller b tx
   input wire logic i2c_scl_o, // i2c clock, 0 pulls low
   input wire logic i2c_sda_o, // i2c data, 0 pulls low
   input wire logic can_access, // register access strobe
   input wire logic [pmx_pkg::PMX_ADDR_W-1:0] can_addr, // access address
   input wire logic [pmx_pkg::PMX_IRQ_LINES-1:0] can_a_irq, // controller a requests
   input wire logic [pmx_pkg::PMX_IRQ_LINES-1:0] can_b_irq, // controller b requests
   input wire logic [pmx_pkg::PMX_IRQ_LINES-1:0] other_irq, // other peripherals
   output pmx_pkg::pmx_pin_drive_t pin_drive, // pin out and enable
   output pmx_pkg::pmx_persel_t peripheral_select_reg, // selection state
   output logic can_parallel_mode, // misc parallel mode bit
   output logic misc_access_ok, // misc register reachable
   output logic can_a_receive, // controller a rx
   output logic can_b_receive, // controller b rx
   output logic i2c_scl_i, // i2c clock level
   output logic i2c_sda_i, // i2c data level
   output logic [pmx_pkg::PMX_PINS-1:0] port_pin_read, // pin levels for the port
   output logic can_a_cs, // chip select a, one cycle
   output logic can_b_cs, // chip select b, one cycle
   output logic [pmx_pkg::PMX_OFS_W-1:0] can_reg_offset, // shared register offset
   output logic [pmx_pkg::PMX_IRQ_LINES-1:0] extension_bus_irq, // merged requests
   output logic [3:0] seg_addr_lines, // usable segment address lines
   output logic [pmx_pkg::PMX_PINS-1:0] ext_addr_pin_ok, // pins free for address out
   output logic [6:0] msg_obj_total // message objects available
);
   import pmx_pkg::*;

   logic [PMX_PINS-1:0] pin_sync;
   pmx_pin_drive_t drive_next;
   logic can_a_en;
   logic can_b_en;
   logic i2c_en;
   logic misc_ok;
   logic canb_side;
   logic a_tx_pin;

   ////////////////////////////////////////////////////////////////////////
   // helpers

   // open-drain drives only a low; push-pull always drives
   function automatic logic [1:0] od_pin(input logic val, input logic od);
      od_pin = od ? {1'b0, ~val} : {val, 1'b1};
   endfunction

   // a decoded address lies in the shared block of the two controllers
   function automatic logic in_can_block(input logic [PMX_ADDR_W-1:0] a);
      in_can_block = (a[PMX_ADDR_W-1:PMX_SEL_BIT+1] == CAN_BASE[PMX_ADDR_W-1:PMX_SEL_BIT+1]);
   endfunction

   pmx_pin_sync #(.WIDTH(PMX_PINS), .RST_VAL(PMX_PIN_IDLE)) u_sync (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .d(pin_in),
      .q(pin_sync)
   );

   ////////////////////////////////////////////////////////////////////////
   // control state

   assign can_a_en = peripheral_select_reg.can_a_enable;
   assign can_b_en = peripheral_select_reg.can_b_enable;
   assign i2c_en = peripheral_select_reg.i2c_block_enable;
   assign misc_ok = peripheral_select_reg.misc_reg_enable & ext_periph_enable;

   // can picks freeze once the extension enable is up
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         peripheral_select_reg <= PMX_PERSEL_RST;
      end else if (persel_wr) begin
         peripheral_select_reg.i2c_block_enable <= persel_wdata.i2c_block_enable;
         peripheral_select_reg.misc_reg_enable <= persel_wdata.misc_reg_enable;
         if (!ext_periph_enable) begin
            peripheral_select_reg.can_a_enable <= persel_wdata.can_a_enable;
            peripheral_select_reg.can_b_enable <= persel_wdata.can_b_enable;
         end
      end
   end

   // misc register, writes dropped while unreachable
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         can_parallel_mode <= 1'b0;
         misc_access_ok <= 1'b0;
      end else begin
         misc_access_ok <= misc_ok;
         if (misc_wr && misc_ok) begin
            can_parallel_mode <= misc_wdata;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // pin routing

   // controller b owns 4.4/4.7 only outside parallel mode and without i2c
   assign canb_side = can_b_en & ~can_parallel_mode & ~i2c_en;
   // parallel mode: both transmitters meet on 4.6, a low wins as on the bus
   assign a_tx_pin = can_parallel_mode ?
      ((can_a_en ? can_a_transmit : PMX_RECESSIVE) & (can_b_en ? can_b_transmit : PMX_RECESSIVE))
      : can_a_transmit;

   always_comb begin
      for (int i = 0; i < PMX_PINS; i++) begin
         // default: plain port pin
         {drive_next.out[i], drive_next.oe[i]} = port_direction_reg[i] ?
            od_pin(port_value_reg[i], port_open_drain_reg[i]) : 2'b00;
      end
      if (i2c_en) begin
         // port registers ignored here
         {drive_next.out[PMX_PIN_B_RX], drive_next.oe[PMX_PIN_B_RX]} =
            od_pin(i2c_scl_o, 1'b1);
         {drive_next.out[PMX_PIN_B_TX], drive_next.oe[PMX_PIN_B_TX]} =
            od_pin(i2c_sda_o, 1'b1);
      end else if (canb_side) begin
         {drive_next.out[PMX_PIN_B_RX], drive_next.oe[PMX_PIN_B_RX]} = 2'b00;
         {drive_next.out[PMX_PIN_B_TX], drive_next.oe[PMX_PIN_B_TX]} =
            od_pin(can_b_transmit, port_open_drain_reg[PMX_PIN_B_TX]);
      end
      if (can_a_en || (can_parallel_mode && can_b_en)) begin
         {drive_next.out[PMX_PIN_A_RX], drive_next.oe[PMX_PIN_A_RX]} = 2'b00;
         {drive_next.out[PMX_PIN_A_TX], drive_next.oe[PMX_PIN_A_TX]} =
            od_pin(a_tx_pin, port_open_drain_reg[PMX_PIN_A_TX]);
      end
   end

   // pins and receive paths
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         pin_drive <= '0;
         can_a_receive <= PMX_RECESSIVE;
         can_b_receive <= PMX_RECESSIVE;
         i2c_scl_i <= 1'b1;
         i2c_sda_i <= 1'b1;
         port_pin_read <= PMX_PIN_IDLE;
      end else begin
         pin_drive <= drive_next;
         port_pin_read <= pin_sync;
         can_a_receive <= can_a_en ? pin_sync[PMX_PIN_A_RX] : PMX_RECESSIVE;
         if (can_parallel_mode && can_b_en) begin
            can_b_receive <= pin_sync[PMX_PIN_A_RX];
         end else if (canb_side) begin
            can_b_receive <= pin_sync[PMX_PIN_B_RX];
         end else begin
            can_b_receive <= PMX_RECESSIVE;
         end
         // idle high when released, like a pulled-up line
         i2c_scl_i <= i2c_en ? pin_sync[PMX_PIN_B_RX] : 1'b1;
         i2c_sda_i <= i2c_en ? pin_sync[PMX_PIN_B_TX] : 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // address decode, interrupts, capacity

   // same offsets for both, bit 8 chooses the controller
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         can_a_cs <= 1'b0;
         can_b_cs <= 1'b0;
         can_reg_offset <= '0;
      end else begin
         can_a_cs <= can_access & in_can_block(can_addr) & ~can_addr[PMX_SEL_BIT] & can_a_en;
         can_b_cs <= can_access & in_can_block(can_addr) & can_addr[PMX_SEL_BIT] & can_b_en;
         can_reg_offset <= can_addr[PMX_OFS_W-1:0];
      end
   end

   // merged requests, external address limits, object count
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         extension_bus_irq <= '0;
         seg_addr_lines <= PMX_SEG_LINES_CAN;
         ext_addr_pin_ok <= '0;
         msg_obj_total <= PMX_MSG_OBJ_PER_CAN;
      end else begin
         extension_bus_irq <= can_a_irq | can_b_irq | other_irq;
         seg_addr_lines <= (can_a_en | can_b_en) ? PMX_SEG_LINES_CAN : PMX_SEG_LINES_ALL;
         ext_addr_pin_ok <= (can_a_en | can_b_en | can_parallel_mode) ?
            '0 : {PMX_PINS{1'b1}};
         msg_obj_total <= 7'((can_a_en ? PMX_MSG_OBJ_PER_CAN : 7'h00) +
            (can_b_en ? PMX_MSG_OBJ_PER_CAN : 7'h00));
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);

   a_i2c_scl_od: assert property (i2c_en && !i2c_scl_o
      |=> pin_drive.oe[PMX_PIN_B_RX] && !pin_drive.out[PMX_PIN_B_RX])
      else $error("i2c clock pin not pulled low");
   a_i2c_ignores_port: assert property (i2c_en && i2c_sda_o && $stable(i2c_en)
      |=> !pin_drive.oe[PMX_PIN_B_TX])
      else $error("port bits leaked onto i2c data pin");
   a_port_pin_back: assert property (!i2c_en && !can_b_en
      && port_direction_reg[PMX_PIN_B_RX] && !port_open_drain_reg[PMX_PIN_B_RX]
      |=> pin_drive.oe[PMX_PIN_B_RX]
      && pin_drive.out[PMX_PIN_B_RX] == $past(port_value_reg[PMX_PIN_B_RX]))
      else $error("released pin not under port control");
   a_can_a_tx: assert property (can_a_en && !can_parallel_mode
      && !port_open_drain_reg[PMX_PIN_A_TX]
      |=> pin_drive.out[PMX_PIN_A_TX] == $past(can_a_transmit) && pin_drive.oe[PMX_PIN_A_TX])
      else $error("controller a tx not on pin 4.6");
   a_can_b_rx: assert property (canb_side
      |=> can_b_receive == $past(pin_sync[PMX_PIN_B_RX]))
      else $error("controller b rx not from pin 4.4");
   a_par_rx_shared: assert property (can_parallel_mode && can_a_en && can_b_en
      |=> can_a_receive == can_b_receive)
      else $error("parallel receive paths differ");
   a_misc_gated: assert property (misc_wr && !misc_ok |=> $stable(can_parallel_mode))
      else $error("misc written while unreachable");
   a_can_freeze: assert property (persel_wr && ext_periph_enable
      |=> peripheral_select_reg.can_b_enable == $past(can_b_en))
      else $error("can selection changed after extension enable");
   a_seg_lines: assert property ((can_a_en || can_b_en)
      |=> seg_addr_lines == PMX_SEG_LINES_CAN)
      else $error("segment lines not limited");
   a_par_no_addr: assert property (can_parallel_mode |=> ext_addr_pin_ok == 4'h0)
      else $error("address use allowed in parallel mode");
   a_cs_split: assert property (can_access && can_addr[PMX_SEL_BIT] && can_b_en
      && in_can_block(can_addr) |=> can_b_cs && !can_a_cs)
      else $error("bit 8 did not pick controller b");
   a_irq_merge: assert property (can_b_irq[2] |=> extension_bus_irq[2])
      else $error("request lost in merge");
   a_two_can_objs: assert property (can_a_en && can_b_en
      |=> msg_obj_total == PMX_MSG_OBJ_PER_CAN + PMX_MSG_OBJ_PER_CAN)
      else $error("object total not 64");

   c_i2c_on: cover property (i2c_en && can_b_en && !can_parallel_mode);
   c_par_mode: cover property (can_parallel_mode && can_a_en && can_b_en);
   c_canb_pins: cover property (canb_side && !can_b_transmit);
   c_cs_b: cover property (can_b_cs);
endmodule

// File: verif/pmx_bus_model.sv
// Purpose: pulled-up far side of port pins 4.4..4.7 (transceiver and i2c lines)
// Assumes: oe high means the router drives the pin
// Notes: the far side pulls a line low only when the bench commands it
`timescale 1ns/1ps
module pmx_bus_model (
   input wire pmx_pkg::pmx_pin_drive_t pin_drive, // router drive
   input wire logic [pmx_pkg::PMX_PINS-1:0] far_low, // far side pulls low
   output logic [pmx_pkg::PMX_PINS-1:0] pin_level // resolved line levels
);
   import pmx_pkg::*;
   ////////////////////////////////////////////////////////////////////////////////
   // wired-and with pull-ups: a released line rises, never keeps its old value
   always_comb begin
      for (int i = 0; i < PMX_PINS; i++) begin
         pin_level[i] = ~far_low[i]
            & (pin_drive.oe[i] ? pin_drive.out[i] : PMX_PIN_IDLE[i]);
      end
   end
endmodule

// File: verif/testbench.sv
// Purpose: random and corner checks of the port 4 pin router
// Assumes: drives on the rising edge, checks at the falling edge
// Notes: waits are the fixed latencies of the router, no open waits
`timescale 1ns/1ps
module testbench;
   import pmx_pkg::*;
   logic sys_clk = 1'b0, rst_b = 1'b0, persel_wr = 1'b0, ext_periph_enable = 1'b0;
   logic misc_wr = 1'b0, misc_wdata = 1'b0, can_access = 1'b0, par = 1'b0;
   logic can_a_transmit = 1'b1, can_b_transmit = 1'b1, i2c_scl_o = 1'b1, i2c_sda_o = 1'b1;
   logic [3:0] port_value_reg = '0, port_direction_reg = '0, port_open_drain_reg = '0;
   logic [3:0] can_a_irq = '0, can_b_irq = '0, other_irq = '0, far_low = '0, pin_in;
   logic [15:0] can_addr = '0;
   pmx_persel_t persel_wdata = '0, sel, peripheral_select_reg;
   pmx_pin_drive_t pin_drive, e;
   logic can_parallel_mode, misc_access_ok, can_a_receive, can_b_receive, i2c_scl_i, i2c_sda_i;
   logic can_a_cs, can_b_cs, hit, any_can;
   logic [3:0] port_pin_read, extension_bus_irq, seg_addr_lines, ext_addr_pin_ok;
   logic [7:0] can_reg_offset;
   logic [6:0] msg_obj_total;
   int mismatches = 0, n_tests = 0;

   always #2 sys_clk = ~sys_clk;

   pmx_router dut_u (.sys_clk, .rst_b, .persel_wr, .persel_wdata, .ext_periph_enable, .misc_wr,
      .misc_wdata, .port_value_reg, .port_direction_reg, .port_open_drain_reg, .pin_in,
      .can_a_transmit, .can_b_transmit, .i2c_scl_o, .i2c_sda_o, .can_access, .can_addr,
      .can_a_irq, .can_b_irq, .other_irq, .pin_drive, .peripheral_select_reg, .can_parallel_mode,
      .misc_access_ok, .can_a_receive, .can_b_receive, .i2c_scl_i, .i2c_sda_i, .port_pin_read,
      .can_a_cs, .can_b_cs, .can_reg_offset, .extension_bus_irq, .seg_addr_lines,
      .ext_addr_pin_ok, .msg_obj_total);
   pmx_bus_model far_u (.pin_drive(pin_drive), .far_low(far_low), .pin_level(pin_in));

   ////////////////////////////////////////////////////////////////////////////////
   // expected pin drive; port open-drain bits only ever pull low
   function automatic pmx_pin_drive_t exp_drive(input pmx_persel_t s, input logic p);
      pmx_pin_drive_t d;
      logic tx;
      d.out = port_value_reg;
      d.oe = port_direction_reg & ~(port_open_drain_reg & port_value_reg);
      tx = (s.can_a_enable ? can_a_transmit : 1'b1)
         & (p & s.can_b_enable ? can_b_transmit : 1'b1);
      if (s.can_a_enable | (p & s.can_b_enable)) begin
         d.oe[1] = 1'b0;
         d.oe[2] = ~(port_open_drain_reg[2] & tx);
         d.out[2] = tx;
      end
      if (s.i2c_block_enable) begin
         d.oe[0] = ~i2c_scl_o;
         d.out[0] = 1'b0;
         d.oe[3] = ~i2c_sda_o;
         d.out[3] = 1'b0;
      end else if (s.can_b_enable & ~p) begin
         d.oe[0] = 1'b0;
         d.oe[3] = ~(port_open_drain_reg[3] & can_b_transmit);
         d.out[3] = can_b_transmit;
      end
      return d;
   endfunction

   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      @(negedge sys_clk);
   endtask

   task automatic wr_sel(input pmx_persel_t d);
      @(posedge sys_clk);
      persel_wr <= 1'b1;
      persel_wdata <= d;
      @(posedge sys_clk);
      persel_wr <= 1'b0;
   endtask

   // raises the extension enable together with the misc write
   task automatic wr_misc(input logic b);
      @(posedge sys_clk);
      ext_periph_enable <= 1'b1;
      misc_wr <= 1'b1;
      misc_wdata <= b;
      @(posedge sys_clk);
      misc_wr <= 1'b0;
   endtask

   task automatic results;
      if (mismatches == 0 && n_tests > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // guard against a hung run
   initial begin
      #100000;
      mismatches++;
      results();
   end

   initial begin
      void'($urandom(25));
      repeat (4) @(posedge sys_clk);
      rst_b <= 1'b1;
      tick(2);
      chk("sel_rst", 8'(PMX_PERSEL_RST), 8'(peripheral_select_reg));
      chk("msg_rst", 8'h20, 8'(msg_obj_total));
      chk("seg_rst", 8'h04, 8'(seg_addr_lines));
      for (int n = 0; n < 60; n++) begin
         @(posedge sys_clk);
         ext_periph_enable <= 1'b0;
         sel = (n == 0) ? 4'hF : 4'($urandom);
         wr_sel(sel);
         hit = 1'($urandom);
         wr_misc(hit);
         if (sel.misc_reg_enable) par = hit;
         // can bits must stay frozen once the extension enable is up
         wr_sel({sel.i2c_block_enable, sel.misc_reg_enable, ~sel.can_b_enable, ~sel.can_a_enable});
         {port_value_reg, port_direction_reg, port_open_drain_reg} <= 12'($urandom);
         {can_a_transmit, can_b_transmit, i2c_scl_o, i2c_sda_o} <= 4'($urandom);
         {can_a_irq, can_b_irq, other_irq} <= 12'($urandom);
         tick(3);
         e = exp_drive(sel, par);
         any_can = sel.can_a_enable | sel.can_b_enable;
         chk("sel", 8'(sel), 8'(peripheral_select_reg));
         chk("par", 8'(par), 8'(can_parallel_mode));
         chk("misc_ok", 8'(sel.misc_reg_enable), 8'(misc_access_ok));
         chk("pin_oe", 8'(e.oe), 8'(pin_drive.oe));
         chk("pin_out", 8'(e.out & e.oe), 8'(pin_drive.out & e.oe));
         chk("seg", any_can ? 8'h04 : 8'h08, 8'(seg_addr_lines));
         chk("addr_ok", (any_can | par) ? 8'h00 : 8'h0F, 8'(ext_addr_pin_ok));
         chk("msg", {1'b0, sel.can_a_enable & sel.can_b_enable, sel.can_a_enable ^ sel.can_b_enable,
            5'h00}, {1'b0, msg_obj_total});
         chk("irq", 8'(can_a_irq | can_b_irq | other_irq), 8'(extension_bus_irq));
         @(posedge sys_clk);
         can_access <= 1'b1;
         can_addr <= {7'($urandom_range(1, 0)), 9'($urandom)};
         @(posedge sys_clk);
         can_access <= 1'b0;
         @(negedge sys_clk);
         hit = (can_addr[15:9] == 7'h00);
         chk("cs_a", 8'(hit & ~can_addr[8] & sel.can_a_enable), 8'(can_a_cs));
         chk("cs_b", 8'(hit & can_addr[8] & sel.can_b_enable), 8'(can_b_cs));
         chk("offset", can_addr[7:0], can_reg_offset);
      end
      // receive paths: port bits released, can and i2c outputs held high, far side pulls low
      @(posedge sys_clk);
      ext_periph_enable <= 1'b0;
      port_direction_reg <= 4'h0;
      {can_a_transmit, can_b_transmit, i2c_scl_o, i2c_sda_o} <= 4'hF;
      wr_sel(4'b0111);
      wr_misc(1'b0);
      far_low <= 4'b0011;
      tick(6);
      chk("rx_a", 8'h00, 8'(can_a_receive));
      chk("rx_b", 8'h00, 8'(can_b_receive));
      wr_misc(1'b1);
      far_low <= 4'b0010;
      tick(6);
      chk("rx_b_par", 8'h00, 8'(can_b_receive));
      wr_misc(1'b0);
      wr_sel(4'hF);
      far_low <= 4'b1001;
      tick(6);
      chk("scl_in", 8'h00, 8'(i2c_scl_i));
      chk("sda_in", 8'h00, 8'(i2c_sda_i));
      chk("rx_b_i2c", 8'h01, 8'(can_b_receive));
      chk("port_rd", 8'h06, 8'(port_pin_read));
      results();
   end
endmodule
